// ===== core/tx_ramp_pll_cal_sequencer.sv
// Transmit ramp, synthesizer settling and calibration sequencer with its registers
// Behaviour
// - After PA enable, wait txmod times 4 us before starting modulation.
// - The same modulation delay also applies during PA ramp down.
// - RF regulator ramps over 5, 10, 15 or 20 us by two-bit code.
// - PA ramps up over 5, 10, 15 or 20 us by two-bit code.
// - Retune from locked frequency waits soft settle, 0 to 310 us, 10 us steps.
// - After calibration allow post settle, 0 to 70 us, 10 us steps.
// - Cold-start settle after calibration is soft plus post settle time.
// - Wake-half bit halves the crystal oscillator wake-up period.
// - Converter calibration done bit reads 1 once that calibration finished.
// - With fine enable set, RC oscillator fine calibrates about every 30 s.
// - Force bit rising starts 2 ms RC calibration; bit clears by itself.
// - RC oscillator calibrates automatically when wake timer or wake-on-receive engages.
// - Double precision bit lengthens the VCO calibration measurement.
// - In idle with synthesizer on, force bit runs one VCO calibration, self-clears.
// - Skip bit omits VCO calibration on idle to transmit or receive.
`timescale 1ns/10ps
`default_nettype none
module tx_ramp_pll_cal_sequencer #(
	parameter int TW                = 25,
	parameter int RC_CAL_US         = seq_pkg::RC_CAL_US,
	parameter int RC_FINE_PERIOD_US = seq_pkg::RC_FINE_US,
	parameter int XTAL_WAKE_US      = seq_pkg::XTAL_WAKE_US,
	parameter int VCO_CAL_US        = seq_pkg::VCO_CAL_US
) (
	// Clock and reset
	input  wire logic       clock_i,
	input  wire logic       rst_n_i,
	// Register port
	input  wire logic [6:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	output logic      [7:0] reg_rdata_o,
	// Radio state events and levels
	input  wire logic       pa_on_i,
	input  wire logic       pa_off_i,
	input  wire logic       retune_i,
	input  wire logic       idle_to_txrx_i,
	input  wire logic       idle_i,
	input  wire logic       synth_on_i,
	input  wire logic       xtal_start_i,
	input  wire logic       wake_timer_en_i,
	input  wire logic       wake_on_rx_i,
	input  wire logic       rc_osc_en_i,
	input  wire logic       adc_cal_done_i,
	// Sequencer outputs
	output logic            ldo_ramp_o,
	output logic            pa_ramp_o,
	output logic            mod_start_o,
	output logic            pa_down_done_o,
	output logic            synth_settled_o,
	output logic            vco_cal_busy_o,
	output logic            rc_cal_busy_o,
	output logic            rc_fine_cal_o,
	output logic            xtal_ready_o,
	output logic            xtal_wake_half_o
);
	localparam int NT = seq_pkg::NUM_T;

	generate
		if (TW < 25 || RC_CAL_US < 1 || RC_FINE_PERIOD_US < 1 || XTAL_WAKE_US < 2
			|| VCO_CAL_US < 1 || RC_FINE_PERIOD_US >= (1 << TW) - 1
			|| 2 * VCO_CAL_US >= (1 << TW) - 1)
		begin : g_bad_param
			$error("Sequencer parameters out of range");
		end
	endgenerate

	function automatic logic [TW-1:0] ramp_us(input logic [1:0] code);
		ramp_us = TW'((int'(code) + 1) * seq_pkg::RAMP_STEP_US);
	endfunction

	// Microsecond tick
	logic [3:0] tick_cnt_r;
	logic [3:0] tick_cnt_nxt;
	logic       tick;

	assign tick = (tick_cnt_r == 4'(seq_pkg::TICK_CYC - 1));

	always_comb
	begin
		tick_cnt_nxt = tick ? 4'h0 : tick_cnt_r + 4'h1;
	end

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			tick_cnt_r <= 4'h0;
		else
			tick_cnt_r <= tick_cnt_nxt;
	end

	// Converter calibration done comes from the analog side
	logic adc_meta_r;
	logic adc_sync_r;

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			adc_meta_r <= 1'b0;
			adc_sync_r <= 1'b0;
		end
		else
		begin
			adc_meta_r <= adc_cal_done_i;
			adc_sync_r <= adc_meta_r;
		end
	end

	// Timers
	logic [TW-1:0] load [NT];
	logic [NT-1:0] start;
	logic [NT-1:0] busy;
	logic [NT-1:0] done;

	generate
		for (genvar i = 0; i < NT; i++)
		begin : g_tmr
			us_timer #(
				.W(TW)
			) u_tmr (
				.clock_i (clock_i),
				.rst_n_i (rst_n_i),
				.tick_i  (tick),
				.start_i (start[i]),
				.load_i  (load[i]),
				.busy_o  (busy[i]),
				.done_o  (done[i])
			);
		end
	endgenerate

	// Registers
	logic [7:0] ramp_r;
	logic [7:0] ramp_nxt;
	logic [7:0] tune_r;
	logic [7:0] tune_nxt;
	logic [7:0] cal_r;
	logic [7:0] cal_nxt;
	logic       mod_down_r;
	logic       mod_down_nxt;
	logic       vco_forced_r;
	logic       vco_forced_nxt;
	logic       rc_forced_r;
	logic       rc_forced_nxt;
	logic       rc_trig_prev_r;
	logic       rc_trig_prev_nxt;
	logic       xtal_ready_r;
	logic       xtal_ready_nxt;
	logic       mod_start_r;
	logic       mod_start_nxt;
	logic       pa_down_r;
	logic       pa_down_nxt;
	logic       settled_r;
	logic       settled_nxt;
	logic       rc_fine_r;
	logic       rc_fine_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;

	logic       wr_cal;
	logic       rc_edge;
	logic       rc_auto;
	logic       vco_force_go;
	logic       vco_auto_go;
	logic [4:0] soft_code;
	logic [2:0] post_code;

	assign wr_cal    = reg_wr_i && (reg_addr_i == seq_pkg::ADDR_CAL);
	assign soft_code = tune_r[seq_pkg::SOFT_LSB +: 5];
	assign post_code = tune_r[seq_pkg::POST_LSB +: 3];
	// A write of 1 in the clearing cycle still counts as a fresh request
	assign rc_edge   = wr_cal && reg_wdata_i[seq_pkg::RC_FORCE_BIT]
		&& (!cal_r[seq_pkg::RC_FORCE_BIT] || (done[seq_pkg::T_RC] && rc_forced_r))
		&& rc_osc_en_i;
	assign rc_auto   = (wake_timer_en_i || wake_on_rx_i) && !rc_trig_prev_r;
	assign vco_force_go = cal_r[seq_pkg::VCO_FORCE_BIT] && idle_i && synth_on_i
		&& !busy[seq_pkg::T_VCO] && !vco_forced_r;
	assign vco_auto_go  = idle_to_txrx_i && !cal_r[seq_pkg::SKIP_VCO_BIT];

	// Timer triggers and loads; each start reloads the timer
	always_comb
	begin
		start = '0;
		start[seq_pkg::T_LDO]  = pa_on_i;
		start[seq_pkg::T_PA]   = pa_on_i || pa_off_i;
		start[seq_pkg::T_MOD]  = pa_on_i || pa_off_i;
		start[seq_pkg::T_SYN]  = done[seq_pkg::T_VCO] || retune_i
			|| (idle_to_txrx_i && cal_r[seq_pkg::SKIP_VCO_BIT]);
		start[seq_pkg::T_VCO]  = vco_force_go || vco_auto_go;
		start[seq_pkg::T_RC]   = rc_edge || rc_auto;
		start[seq_pkg::T_PER]  = cal_r[seq_pkg::RC_FINE_BIT] && !busy[seq_pkg::T_PER]
			&& !done[seq_pkg::T_PER];
		start[seq_pkg::T_XTAL] = xtal_start_i;

		load[seq_pkg::T_LDO] = ramp_us(ramp_r[seq_pkg::LDORAMP_LSB +: 2]);
		load[seq_pkg::T_PA]  = ramp_us(ramp_r[seq_pkg::TXRAMP_LSB +: 2]);
		load[seq_pkg::T_MOD] = TW'(int'(ramp_r[seq_pkg::TXMOD_LSB +: 3])
			* seq_pkg::MOD_STEP_US);
		// After a calibration the whole cold-start time applies
		if (done[seq_pkg::T_VCO])
			load[seq_pkg::T_SYN] = TW'((int'(soft_code) + int'(post_code))
				* seq_pkg::SETTLE_STEP_US);
		else
			load[seq_pkg::T_SYN] = TW'(int'(soft_code) * seq_pkg::SETTLE_STEP_US);
		load[seq_pkg::T_VCO] = cal_r[seq_pkg::VCO_DP_BIT] ? TW'(2 * VCO_CAL_US)
			: TW'(VCO_CAL_US);
		load[seq_pkg::T_RC]  = TW'(RC_CAL_US);
		load[seq_pkg::T_PER] = TW'(RC_FINE_PERIOD_US);
		load[seq_pkg::T_XTAL] = cal_r[seq_pkg::XTAL_HALF_BIT] ? TW'(XTAL_WAKE_US / 2)
			: TW'(XTAL_WAKE_US);
	end

	// Register file, sequencing flags and output pulses
	always_comb
	begin
		ramp_nxt         = ramp_r;
		tune_nxt         = tune_r;
		cal_nxt          = cal_r;
		mod_down_nxt     = mod_down_r;
		vco_forced_nxt   = vco_forced_r;
		rc_forced_nxt    = rc_forced_r;
		rc_trig_prev_nxt = wake_timer_en_i || wake_on_rx_i;
		xtal_ready_nxt   = xtal_ready_r;
		rdata_nxt        = rdata_r;

		if (pa_off_i)
			mod_down_nxt = 1'b1;
		else if (pa_on_i)
			mod_down_nxt = 1'b0;

		// Self-clearing force bits drop when their calibration ends
		if (done[seq_pkg::T_VCO] && vco_forced_r)
		begin
			cal_nxt[seq_pkg::VCO_FORCE_BIT] = 1'b0;
			vco_forced_nxt = 1'b0;
		end
		if (vco_force_go)
			vco_forced_nxt = 1'b1;
		if (done[seq_pkg::T_RC] && rc_forced_r)
		begin
			cal_nxt[seq_pkg::RC_FORCE_BIT] = 1'b0;
			rc_forced_nxt = 1'b0;
		end
		// An automatic restart keeps a pending forced clear alive
		if (rc_edge)
			rc_forced_nxt = 1'b1;

		if (reg_wr_i)
		begin
			unique case (reg_addr_i)
				seq_pkg::ADDR_RAMP: ramp_nxt = reg_wdata_i;
				seq_pkg::ADDR_TUNE: tune_nxt = reg_wdata_i;
				seq_pkg::ADDR_CAL:
				begin
					// Write after self-clear, so a new set wins
					cal_nxt = (reg_wdata_i & seq_pkg::CAL_WR_MASK)
						| (cal_r & ~seq_pkg::CAL_WR_MASK);
					if (!rc_osc_en_i)
						cal_nxt[seq_pkg::RC_FORCE_BIT] = cal_r[seq_pkg::RC_FORCE_BIT];
				end
				default: ;
			endcase
		end

		if (xtal_start_i)
			xtal_ready_nxt = 1'b0;
		else if (done[seq_pkg::T_XTAL])
			xtal_ready_nxt = 1'b1;

		mod_start_nxt = done[seq_pkg::T_MOD] && !mod_down_r;
		pa_down_nxt   = done[seq_pkg::T_MOD] && mod_down_r;
		settled_nxt   = done[seq_pkg::T_SYN];
		rc_fine_nxt   = done[seq_pkg::T_PER] && cal_r[seq_pkg::RC_FINE_BIT];

		if (reg_rd_i)
		begin
			unique case (reg_addr_i)
				seq_pkg::ADDR_RAMP: rdata_nxt = ramp_r;
				seq_pkg::ADDR_TUNE: rdata_nxt = tune_r;
				seq_pkg::ADDR_CAL:
				begin
					rdata_nxt = cal_r & seq_pkg::CAL_WR_MASK;
					rdata_nxt[seq_pkg::ADC_DONE_BIT] = adc_sync_r;
				end
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ramp_r         <= seq_pkg::RAMP_RST;
			tune_r         <= seq_pkg::TUNE_RST;
			cal_r          <= seq_pkg::CAL_RST;
			mod_down_r     <= 1'b0;
			vco_forced_r   <= 1'b0;
			rc_forced_r    <= 1'b0;
			rc_trig_prev_r <= 1'b0;
			xtal_ready_r   <= 1'b0;
			mod_start_r    <= 1'b0;
			pa_down_r      <= 1'b0;
			settled_r      <= 1'b0;
			rc_fine_r      <= 1'b0;
			rdata_r        <= 8'h00;
		end
		else
		begin
			ramp_r         <= ramp_nxt;
			tune_r         <= tune_nxt;
			cal_r          <= cal_nxt;
			mod_down_r     <= mod_down_nxt;
			vco_forced_r   <= vco_forced_nxt;
			rc_forced_r    <= rc_forced_nxt;
			rc_trig_prev_r <= rc_trig_prev_nxt;
			xtal_ready_r   <= xtal_ready_nxt;
			mod_start_r    <= mod_start_nxt;
			pa_down_r      <= pa_down_nxt;
			settled_r      <= settled_nxt;
			rc_fine_r      <= rc_fine_nxt;
			rdata_r        <= rdata_nxt;
		end
	end

	assign reg_rdata_o      = rdata_r;
	assign ldo_ramp_o       = busy[seq_pkg::T_LDO];
	assign pa_ramp_o        = busy[seq_pkg::T_PA];
	assign mod_start_o      = mod_start_r;
	assign pa_down_done_o   = pa_down_r;
	assign synth_settled_o  = settled_r;
	assign vco_cal_busy_o   = busy[seq_pkg::T_VCO];
	assign rc_cal_busy_o    = busy[seq_pkg::T_RC];
	assign rc_fine_cal_o    = rc_fine_r;
	assign xtal_ready_o     = xtal_ready_r;
	assign xtal_wake_half_o = cal_r[seq_pkg::XTAL_HALF_BIT];
endmodule
`default_nettype wire

// ===== include/seq_pkg.sv
// Constants shared by the transmit ramp and synthesizer calibration sequencer
package seq_pkg;
	// Register offsets
	localparam logic [6:0] ADDR_RAMP = 7'h52;
	localparam logic [6:0] ADDR_TUNE = 7'h53;
	localparam logic [6:0] ADDR_CAL  = 7'h55;

	// Reset values
	localparam logic [7:0] RAMP_RST = 8'h00;
	localparam logic [7:0] TUNE_RST = 8'h52;
	localparam logic [7:0] CAL_RST  = 8'h04;

	// Ramp control fields
	localparam int TXMOD_LSB  = 4;
	localparam int LDORAMP_LSB = 2;
	localparam int TXRAMP_LSB = 0;

	// Tune time fields
	localparam int SOFT_LSB = 3;
	localparam int POST_LSB = 0;

	// Calibration control bits
	localparam int XTAL_HALF_BIT = 6;
	localparam int ADC_DONE_BIT  = 5;
	localparam int RC_FINE_BIT   = 4;
	localparam int RC_FORCE_BIT  = 3;
	localparam int VCO_DP_BIT    = 2;
	localparam int VCO_FORCE_BIT = 1;
	localparam int SKIP_VCO_BIT  = 0;
	localparam logic [7:0] CAL_WR_MASK = 8'h5f;

	// Timing
	localparam int CLK_HZ         = 10_000_000;
	localparam int TICK_US        = 1;
	localparam int TICK_CYC       = (CLK_HZ / 1_000_000) * TICK_US;
	localparam int MOD_STEP_US    = 4;
	localparam int RAMP_STEP_US   = 5;
	localparam int SETTLE_STEP_US = 10;
	localparam int RC_CAL_MS      = 2;
	localparam int RC_CAL_US      = RC_CAL_MS * 1000;
	localparam int RC_FINE_S      = 30;
	localparam int RC_FINE_US     = RC_FINE_S * 1_000_000;
	localparam int XTAL_WAKE_US   = 1000;
	localparam int VCO_CAL_US     = 50;

	// Timer slots
	localparam int T_LDO  = 0;
	localparam int T_PA   = 1;
	localparam int T_MOD  = 2;
	localparam int T_SYN  = 3;
	localparam int T_VCO  = 4;
	localparam int T_RC   = 5;
	localparam int T_PER  = 6;
	localparam int T_XTAL = 7;
	localparam int NUM_T  = 8;
endpackage

// ===== core/us_timer.sv
// Restartable microsecond down-counter driven by a shared tick
`timescale 1ns/10ps
`default_nettype none
module us_timer #(
	parameter int W = 25
) (
	// Clock and reset
	input  wire logic         clock_i,
	input  wire logic         rst_n_i,
	// Control
	input  wire logic         tick_i,
	input  wire logic         start_i,
	input  wire logic [W-1:0] load_i,
	// Status
	output logic              busy_o,
	output logic              done_o
);
	logic [W-1:0] count_r;
	logic [W-1:0] count_nxt;
	logic         busy_r;
	logic         busy_nxt;
	logic         done_r;
	logic         done_nxt;

	// Load of N ends after N+1 ticks, so the wait is never short of N us
	always_comb
	begin
		count_nxt = count_r;
		busy_nxt  = busy_r;
		done_nxt  = 1'b0;
		if (start_i)
		begin
			count_nxt = load_i;
			busy_nxt  = 1'b1;
		end
		else if (busy_r && tick_i)
		begin
			if (count_r == '0)
			begin
				busy_nxt = 1'b0;
				done_nxt = 1'b1;
			end
			else
			begin
				count_nxt = count_r - 1'b1;
			end
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			count_r <= '0;
			busy_r  <= 1'b0;
			done_r  <= 1'b0;
		end
		else
		begin
			count_r <= count_nxt;
			busy_r  <= busy_nxt;
			done_r  <= done_nxt;
		end
	end

	assign busy_o = busy_r;
	assign done_o = done_r;
endmodule
`default_nettype wire

// ===== tb/tx_ramp_pll_cal_sequencer_chk.sv
// Port-level assertions for the ramp and calibration sequencer
`timescale 1ns/10ps
`default_nettype none
module tx_ramp_pll_cal_sequencer_chk (
	// Clock, reset and register port
	input wire logic       clock_i,
	input wire logic       rst_n_i,
	input wire logic [6:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic       reg_wr_i,
	input wire logic       reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	// Events and outputs
	input wire logic       pa_on_i,
	input wire logic       pa_off_i,
	input wire logic       idle_to_txrx_i,
	input wire logic       idle_i,
	input wire logic       synth_on_i,
	input wire logic       xtal_start_i,
	input wire logic       ldo_ramp_o,
	input wire logic       pa_ramp_o,
	input wire logic       mod_start_o,
	input wire logic       vco_cal_busy_o,
	input wire logic       rc_cal_busy_o,
	input wire logic       xtal_ready_o,
	input wire logic       xtal_wake_half_o
);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_n_i);
	sequence s_ramps_up;
		ldo_ramp_o && pa_ramp_o && !mod_start_o;
	endsequence
	sequence s_cal_write;
		reg_wr_i && reg_addr_i == seq_pkg::ADDR_CAL;
	endsequence
	a_ramps_start: assert property (pa_on_i |=> s_ramps_up)
		else $error("ramps not started after PA enable");
	a_ldo_min_len: assert property ($rose(ldo_ramp_o) |-> ldo_ramp_o[*8])
		else $error("regulator ramp too short");
	a_pa_down_ramp: assert property (pa_off_i |=> pa_ramp_o)
		else $error("PA ramp not running on ramp down");
	a_mod_one_pulse: assert property (mod_start_o |=> !mod_start_o)
		else $error("modulation start longer than a cycle");
	a_half_follows: assert property (s_cal_write |-> ##2
		(xtal_wake_half_o == $past(reg_wdata_i[6], 2)))
		else $error("wake halving output does not follow register");
	a_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("read data changed without a read");
	a_vco_cause: assert property ($rose(vco_cal_busy_o) |->
		$past(idle_i && synth_on_i || idle_to_txrx_i))
		else $error("VCO calibration started without cause");
	a_rc_min_len: assert property ($rose(rc_cal_busy_o) |-> rc_cal_busy_o[*8])
		else $error("RC calibration too short");
	a_xtal_restart: assert property (xtal_start_i |=> !xtal_ready_o)
		else $error("crystal ready not cleared by new wake");
endmodule
bind tx_ramp_pll_cal_sequencer tx_ramp_pll_cal_sequencer_chk u_chk (.clock_i, .rst_n_i,
	.reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .pa_on_i, .pa_off_i,
	.idle_to_txrx_i, .idle_i, .synth_on_i, .xtal_start_i, .ldo_ramp_o, .pa_ramp_o,
	.mod_start_o, .vco_cal_busy_o, .rc_cal_busy_o, .xtal_ready_o, .xtal_wake_half_o);
`default_nettype wire

// ===== tb/tx_ramp_pll_cal_sequencer_tb.sv
// Self-checking bench for the ramp and calibration sequencer
`timescale 1ns/10ps
`default_nettype none
module tx_ramp_pll_cal_sequencer_tb;
	localparam logic [6:0] A_R = seq_pkg::ADDR_RAMP;
	localparam logic [6:0] A_T = seq_pkg::ADDR_TUNE;
	localparam logic [6:0] A_C = seq_pkg::ADDR_CAL;
	// Short calibration times keep the run small
	localparam int VCO_US = 2;
	localparam int RC_US  = 3;
	logic       clk = 0;
	logic       rst_n = 0;
	logic [6:0] addr = '0;
	logic [7:0] wd = '0;
	logic       wr = 0;
	logic       rd = 0;
	logic [4:0] ev = '0;
	logic       idle = 0;
	logic       syn_on = 1;
	logic       wt = 0;
	logic       wrx = 0;
	logic       rc_en = 1;
	logic       adc = 0;
	logic [7:0] rdata;
	logic       half;
	wire  [8:0] mon;
	int         num_errors = 0;
	int         cmp_count = 0;
	int         f[9];
	int         l[9];
	always #50 clk = ~clk;
	tx_ramp_pll_cal_sequencer #(.RC_CAL_US(RC_US), .RC_FINE_PERIOD_US(20), .XTAL_WAKE_US(4),
		.VCO_CAL_US(VCO_US)) u_tx_ramp_pll_cal_sequencer (.clock_i(clk), .rst_n_i(rst_n),
		.reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
		.pa_on_i(ev[0]), .pa_off_i(ev[1]), .retune_i(ev[2]), .idle_to_txrx_i(ev[3]),
		.idle_i(idle), .synth_on_i(syn_on), .xtal_start_i(ev[4]), .wake_timer_en_i(wt),
		.wake_on_rx_i(wrx), .rc_osc_en_i(rc_en), .adc_cal_done_i(adc), .ldo_ramp_o(mon[0]),
		.pa_ramp_o(mon[1]), .mod_start_o(mon[2]), .pa_down_done_o(mon[3]),
		.synth_settled_o(mon[4]), .vco_cal_busy_o(mon[5]), .rc_cal_busy_o(mon[6]),
		.rc_fine_cal_o(mon[8]), .xtal_ready_o(mon[7]), .xtal_wake_half_o(half));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	// Shared free-running tick makes each wait N to N+1 us plus a cycle
	task automatic win(input int got, input int n);
		cmp_count++;
		// Zero means the event never showed within the bound
		if (got <= 0 || got < n * 10 || got > n * 10 + 12)
		begin
			num_errors++;
			$display("Error at %0t: took %0d cycles for %0d us", $time, got, n);
		end
	endtask
	task automatic wreg(input logic [6:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wd = d;
		wr = 1;
		@(negedge clk);
		wr = 0;
	endtask
	task automatic rreg(input logic [6:0] a, input logic [7:0] e);
		@(negedge clk);
		addr = a;
		rd = 1;
		@(negedge clk);
		rd = 0;
		chk(rdata, e);
	endtask
	task automatic go(input int i);
		@(negedge clk);
		ev[i] = 1;
		@(negedge clk);
		ev[i] = 0;
	endtask
	// First and last cycle each output is seen high
	task automatic run(input int lim);
		for (int b = 0; b < 9; b++)
		begin
			f[b] = 0;
			l[b] = 0;
		end
		for (int n = 1; n <= lim; n++)
		begin
			@(posedge clk);
			#1;
			for (int b = 0; b < 9; b++)
				if (mon[b] === 1'b1)
				begin
					if (f[b] == 0)
						f[b] = n;
					l[b] = n;
				end
		end
	endtask
	task automatic tally_and_finish;
		$display("Comparisons %0d, errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (2) @(posedge clk);
		@(negedge clk);
		rst_n = 1;
		rreg(A_R, seq_pkg::RAMP_RST);
		rreg(A_T, seq_pkg::TUNE_RST);
		rreg(A_C, seq_pkg::CAL_RST);
		rreg(7'h54, 8'h00);
		for (int i = 0; i < 8; i++)
		begin
			wreg(A_R, {1'b0, i[2:0], i[1:0], ~i[1:0]});
			rreg(A_R, {1'b0, i[2:0], i[1:0], ~i[1:0]});
			go(0);
			run(320);
			win(f[2], i * 4);
			win(l[0], (i % 4 + 1) * 5);
			win(l[1], (4 - i % 4) * 5);
			go(1);
			run(320);
			win(f[3], i * 4);
			win(l[1], (4 - i % 4) * 5);
			chk(l[0], 0);
		end
		wreg(A_T, 8'hff);
		go(2);
		run(3200);
		win(f[4], 310);
		wreg(A_T, 8'h0a);
		go(2);
		run(120);
		win(f[4], 10);
		wreg(A_C, 8'h01);
		go(3);
		run(200);
		chk(l[5], 0);
		win(f[4], 10);
		wreg(A_C, 8'h00);
		go(3);
		run(400);
		win(l[5], VCO_US);
		win(f[4] - l[5], 30);
		wreg(A_C, 8'h04);
		go(3);
		run(400);
		win(l[5], 2 * VCO_US);
		wreg(A_C, 8'h02);
		run(40);
		chk(l[5], 0);
		@(negedge clk);
		idle = 1;
		run(400);
		win(l[5], VCO_US);
		win(f[4] - l[5], 30);
		rreg(A_C, 8'h00);
		idle = 0;
		rc_en = 0;
		wreg(A_C, 8'h08);
		rreg(A_C, 8'h00);
		rc_en = 1;
		wreg(A_C, 8'h08);
		run(60);
		win(l[6], RC_US);
		rreg(A_C, 8'h00);
		// Auto start during a forced run must not strand the force bit
		wreg(A_C, 8'h08);
		@(negedge clk);
		wt = 1;
		run(60);
		win(l[6], RC_US);
		rreg(A_C, 8'h00);
		@(negedge clk);
		wt = 0;
		repeat (2) @(negedge clk);
		wrx = 1;
		run(60);
		win(l[6], RC_US);
		wreg(A_C, 8'h10);
		run(230);
		win(f[8], 20);
		for (int h = 0; h < 2; h++)
		begin
			wreg(A_C, {1'b0, h[0], 6'h00});
			go(4);
			run(60);
			win(f[7], 4 >> h);
			chk(half, h[0]);
		end
		@(negedge clk);
		adc = 1;
		repeat (3) @(negedge clk);
		rreg(A_C, 8'h60);
		tally_and_finish;
	end
endmodule
`default_nettype wire
